// ===== hdl/lcpc_pkg.sv
// Package with register map, field layout, reset values and timing constants
package lcpc_pkg;

	// Channel count and staging layout: duty words first, then control words
	localparam int unsigned LCPC_NUM_CH = 36;
	localparam int unsigned LCPC_STAGE_DEPTH = 72;
	localparam int unsigned LCPC_STAGE_AW = 7;

	// Register offsets (byte addresses on the serial register link)
	localparam logic [7:0] LCPC_ADDR_SHUTDOWN = 8'h00;
	localparam logic [7:0] LCPC_ADDR_DUTY_FIRST = 8'h01;
	localparam logic [7:0] LCPC_ADDR_DUTY_LAST = 8'h24;
	localparam logic [7:0] LCPC_ADDR_UPDATE = 8'h25;
	localparam logic [7:0] LCPC_ADDR_CTRL_FIRST = 8'h26;
	localparam logic [7:0] LCPC_ADDR_CTRL_LAST = 8'h49;
	localparam logic [7:0] LCPC_ADDR_GLOBAL = 8'h4A;
	localparam logic [7:0] LCPC_ADDR_RATE = 8'h4B;
	localparam logic [7:0] LCPC_ADDR_RESET = 8'h4F;

	// Trigger value for update and reset registers
	localparam logic [7:0] LCPC_TRIGGER_VALUE = 8'h00;

	// Field positions
	localparam int unsigned LCPC_SOFT_POWER_DOWN_BIT = 0;
	localparam int unsigned LCPC_CH_ENABLE_BIT = 0;
	localparam int unsigned LCPC_CURRENT_SCALE_LSB = 1;
	localparam int unsigned LCPC_CTRL_WIDTH = 3;
	localparam int unsigned LCPC_GLOBAL_OFF_BIT = 0;
	localparam int unsigned LCPC_PWM_RATE_SELECT_BIT = 0;

	// Reset values
	localparam logic LCPC_SOFT_POWER_DOWN_RST = 1'b0;
	localparam logic LCPC_GLOBAL_OFF_RST = 1'b0;
	localparam logic LCPC_PWM_RATE_SELECT_RST = 1'b0;
	localparam logic [7:0] LCPC_DUTY_RST = 8'h00;
	localparam logic [2:0] LCPC_CTRL_RST = 3'h0;
	localparam logic [7:0] LCPC_PTR_RST = 8'h00;

	// Timing: PWM frequencies in Hz, 256 counts per PWM period
	localparam int unsigned LCPC_PWM_STEPS = 256;
	localparam int unsigned LCPC_PWM_SLOW_HZ = 3000;
	localparam int unsigned LCPC_PWM_FAST_HZ = 22000;
	localparam int unsigned LCPC_CLK_HZ = 125000000;

	// Update sweep states
	typedef enum logic [1:0] {
		LCPC_ST_IDLE = 2'b01,
		LCPC_ST_UPDATE = 2'b10
	} lcpc_state_type;

endpackage

// ===== hdl/lcpc_stage_mem.sv
// Staging memory for duty and control bytes, with clear and registered read
`timescale 1ns/1ns
module lcpc_stage_mem #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 72,
	parameter int unsigned AW = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic clr,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd_data;
	} lcpc_mem_type;

	lcpc_mem_type cur_ff;
	lcpc_mem_type nxt_mem;

	initial begin
		if (DEPTH < 1 || DEPTH > (1 << AW)) begin
			$error("lcpc_stage_mem: DEPTH does not fit address width");
		end
	end

	// Clear wins over a write in the same cycle; reads beyond DEPTH return zero
	always_comb begin
		nxt_mem = cur_ff;
		if (int'(rd_addr) < DEPTH) begin
			nxt_mem.rd_data = cur_ff.mem[rd_addr];
		end else begin
			nxt_mem.rd_data = '0;
		end
		if (clr) begin
			nxt_mem.mem = '0;
		end else if (wr_en && int'(wr_addr) < DEPTH) begin
			nxt_mem.mem[wr_addr] = wr_data;
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_mem;
		end
	end

	assign rd_data = cur_ff.rd_data;

endmodule

// ===== hdl/lcpc_top.sv
// 36-channel LED PWM controller: register file, staging update, shared PWM timebase
`timescale 1ns/1ns
module lcpc_top
	import lcpc_pkg::*;
#(
	parameter int unsigned CLK_HZ = LCPC_CLK_HZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register write link from the serial front end
	input wire logic reg_addr_valid,
	input wire logic [7:0] reg_addr,
	input wire logic reg_data_valid,
	input wire logic [7:0] reg_data,
	// Hardware shutdown pin
	input wire logic hard_power_down_n,
	// LED channel drive
	output logic [LCPC_NUM_CH-1:0] channel_outputs,
	output logic [2*LCPC_NUM_CH-1:0] current_scale,
	// Status
	output logic device_active
);

	// Prescaler divisors, rounded to the nearest whole cycle
	localparam int unsigned SLOW_DIV_INT =
		(CLK_HZ + (LCPC_PWM_SLOW_HZ * LCPC_PWM_STEPS) / 2) / (LCPC_PWM_SLOW_HZ * LCPC_PWM_STEPS);
	localparam int unsigned FAST_DIV_INT =
		(CLK_HZ + (LCPC_PWM_FAST_HZ * LCPC_PWM_STEPS) / 2) / (LCPC_PWM_FAST_HZ * LCPC_PWM_STEPS);
	localparam logic [7:0] SLOW_DIV_LAST = 8'(SLOW_DIV_INT - 1);
	localparam logic [7:0] FAST_DIV_LAST = 8'(FAST_DIV_INT - 1);

	initial begin
		if (SLOW_DIV_INT < 1 || SLOW_DIV_INT > 256 || FAST_DIV_INT < 1) begin
			$error("lcpc_top: CLK_HZ gives a prescaler outside 1..256");
		end
	end

	typedef struct packed {
		lcpc_state_type state;
		logic [7:0] ptr;
		logic [LCPC_STAGE_AW-1:0] upd_idx;
		logic upd_rd_vld;
		logic [LCPC_STAGE_AW-1:0] upd_rd_idx;
		logic soft_on;
		logic glob_off;
		logic rate_fast;
		logic [LCPC_NUM_CH-1:0][7:0] duty;
		logic [LCPC_NUM_CH-1:0][2:0] ctrl;
		logic [7:0] presc;
		logic [7:0] pwm_cnt;
		logic [LCPC_NUM_CH-1:0] outs;
		logic [1:0] sync;
	} lcpc_main_type;

	lcpc_main_type cur_ff;
	lcpc_main_type nxt_main;

	logic mem_wr_en;
	logic [LCPC_STAGE_AW-1:0] mem_wr_addr;
	logic [7:0] mem_wr_data;
	logic mem_clr;
	logic [7:0] mem_rd_data;
	logic [LCPC_NUM_CH-1:0] chan_on;
	logic hw_down;
	logic run;

	// Staging copies of duty and control bytes
	lcpc_stage_mem #(
		.WIDTH(8),
		.DEPTH(LCPC_STAGE_DEPTH),
		.AW(LCPC_STAGE_AW)
	) u_stage (
		.clk(clk),
		.nrst(nrst),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data),
		.clr(mem_clr),
		.rd_addr(cur_ff.upd_idx),
		.rd_data(mem_rd_data)
	);

	// Per-channel compare against the shared counter
	for (genvar ch = 0; ch < LCPC_NUM_CH; ch++) begin : g_chan
		assign chan_on[ch] = cur_ff.ctrl[ch][LCPC_CH_ENABLE_BIT]
			&& (cur_ff.pwm_cnt < cur_ff.duty[ch]);
		assign current_scale[2*ch +: 2] = cur_ff.ctrl[ch][LCPC_CURRENT_SCALE_LSB +: 2];
	end

	// Second synchroniser stage only; the first stage is read by nothing else
	assign hw_down = !cur_ff.sync[1];
	assign run = cur_ff.soft_on && !cur_ff.glob_off && !hw_down;

	// Next-state logic
	always_comb begin
		nxt_main = cur_ff;
		mem_wr_en = 1'b0;
		mem_wr_addr = '0;
		mem_wr_data = 8'h00;
		mem_clr = 1'b0;
		nxt_main.sync = {cur_ff.sync[0], hard_power_down_n};

		// Shared timebase, held at zero in hardware shutdown so the period restarts cleanly
		if (hw_down) begin
			nxt_main.presc = 8'h00;
			nxt_main.pwm_cnt = 8'h00;
		// At or past the limit, so a switch to the faster rate never wraps the prescaler
		end else if (cur_ff.presc >= (cur_ff.rate_fast ? FAST_DIV_LAST : SLOW_DIV_LAST)) begin
			nxt_main.presc = 8'h00;
			nxt_main.pwm_cnt = cur_ff.pwm_cnt + 8'h01;
		end else begin
			nxt_main.presc = cur_ff.presc + 8'h01;
		end

		// Update sweep: one staging word per cycle, read data lands a cycle later
		nxt_main.upd_rd_vld = 1'b0;
		case (cur_ff.state)
			LCPC_ST_IDLE: begin
				nxt_main.state = LCPC_ST_IDLE;
			end
			LCPC_ST_UPDATE: begin
				nxt_main.upd_rd_vld = 1'b1;
				nxt_main.upd_rd_idx = cur_ff.upd_idx;
				if (cur_ff.upd_idx == LCPC_STAGE_AW'(LCPC_STAGE_DEPTH - 1)) begin
					nxt_main.state = LCPC_ST_IDLE;
				end else begin
					nxt_main.upd_idx = cur_ff.upd_idx + 1'b1;
				end
			end
			default: begin
				nxt_main.state = LCPC_ST_IDLE;
			end
		endcase
		if (cur_ff.upd_rd_vld) begin
			if (cur_ff.upd_rd_idx < LCPC_STAGE_AW'(LCPC_NUM_CH)) begin
				nxt_main.duty[6'(cur_ff.upd_rd_idx)] = mem_rd_data;
			end else begin
				nxt_main.ctrl[6'(cur_ff.upd_rd_idx - LCPC_STAGE_AW'(LCPC_NUM_CH))] =
					mem_rd_data[LCPC_CTRL_WIDTH-1:0];
			end
		end

		// Host writes; ignored in hardware shutdown, so only a sweep already running changes duty and control there
		if (reg_addr_valid && !hw_down) begin
			nxt_main.ptr = reg_addr;
		end else if (reg_data_valid && !hw_down) begin
			nxt_main.ptr = cur_ff.ptr + 8'h01;
			if (cur_ff.ptr == LCPC_ADDR_SHUTDOWN) begin
				nxt_main.soft_on = reg_data[LCPC_SOFT_POWER_DOWN_BIT];
			end else if (cur_ff.ptr >= LCPC_ADDR_DUTY_FIRST && cur_ff.ptr <= LCPC_ADDR_DUTY_LAST) begin
				mem_wr_en = 1'b1;
				mem_wr_addr = LCPC_STAGE_AW'(cur_ff.ptr - LCPC_ADDR_DUTY_FIRST);
				mem_wr_data = reg_data;
			end else if (cur_ff.ptr == LCPC_ADDR_UPDATE) begin
				if (reg_data == LCPC_TRIGGER_VALUE) begin
					// A new trigger mid-sweep restarts it so the last writes are caught
					nxt_main.state = LCPC_ST_UPDATE;
					nxt_main.upd_idx = '0;
				end
			end else if (cur_ff.ptr >= LCPC_ADDR_CTRL_FIRST && cur_ff.ptr <= LCPC_ADDR_CTRL_LAST) begin
				mem_wr_en = 1'b1;
				mem_wr_addr = LCPC_STAGE_AW'(cur_ff.ptr - LCPC_ADDR_CTRL_FIRST + 8'(LCPC_NUM_CH));
				mem_wr_data = {5'h00, reg_data[LCPC_CTRL_WIDTH-1:0]};
			end else if (cur_ff.ptr == LCPC_ADDR_GLOBAL) begin
				nxt_main.glob_off = reg_data[LCPC_GLOBAL_OFF_BIT];
			end else if (cur_ff.ptr == LCPC_ADDR_RATE) begin
				nxt_main.rate_fast = reg_data[LCPC_PWM_RATE_SELECT_BIT];
			end else if (cur_ff.ptr == LCPC_ADDR_RESET) begin
				if (reg_data == LCPC_TRIGGER_VALUE) begin
					// Restore defaults, staging included; any sweep in flight is dropped
					mem_clr = 1'b1;
					nxt_main.state = LCPC_ST_IDLE;
					nxt_main.upd_idx = '0;
					nxt_main.upd_rd_vld = 1'b0;
					nxt_main.soft_on = LCPC_SOFT_POWER_DOWN_RST;
					nxt_main.glob_off = LCPC_GLOBAL_OFF_RST;
					nxt_main.rate_fast = LCPC_PWM_RATE_SELECT_RST;
					nxt_main.duty = {LCPC_NUM_CH{LCPC_DUTY_RST}};
					nxt_main.ctrl = {LCPC_NUM_CH{LCPC_CTRL_RST}};
				end
			end
		end

		// Outputs gated by soft, global and hardware shutdown
		nxt_main.outs = chan_on & {LCPC_NUM_CH{run}};
	end

	// State register; every output starts dark
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_ff <= '0;
			cur_ff.state <= LCPC_ST_IDLE;
			cur_ff.ptr <= LCPC_PTR_RST;
			cur_ff.soft_on <= LCPC_SOFT_POWER_DOWN_RST;
			cur_ff.glob_off <= LCPC_GLOBAL_OFF_RST;
			cur_ff.rate_fast <= LCPC_PWM_RATE_SELECT_RST;
		end else begin
			cur_ff <= nxt_main;
		end
	end

	assign channel_outputs = cur_ff.outs;
	assign device_active = cur_ff.soft_on && !hw_down;

endmodule

// ===== verification/lcpc_top_assertions.sv
// Port-level checker for the LED PWM controller
`timescale 1ns/1ns
module lcpc_top_assertions
	import lcpc_pkg::*;
#(
	parameter int unsigned CLK_HZ = LCPC_CLK_HZ
) (
	// Watched ports
	input wire logic clk,
	input wire logic nrst,
	input wire logic reg_addr_valid,
	input wire logic [7:0] reg_addr,
	input wire logic reg_data_valid,
	input wire logic [7:0] reg_data,
	input wire logic hard_power_down_n,
	input wire logic [LCPC_NUM_CH-1:0] channel_outputs,
	input wire logic [2*LCPC_NUM_CH-1:0] current_scale,
	input wire logic device_active
);
	logic [7:0] ptr_ff;
	logic [3:0] pin_ff;
	logic [6:0] since_ff;
	logic live;
	logic wr;
	// Pin counted high only once it has surely crossed the synchroniser
	assign live = (&pin_ff) && hard_power_down_n;
	assign wr = reg_data_valid && !reg_addr_valid && live;
	// Pointer mirror and cycles since the last trigger write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ptr_ff <= LCPC_PTR_RST;
			pin_ff <= 4'h0;
			since_ff <= 7'h7F;
		end else begin
			pin_ff <= {pin_ff[2:0], hard_power_down_n};
			if (reg_addr_valid && live) begin
				ptr_ff <= reg_addr;
			end else if (wr) begin
				ptr_ff <= ptr_ff + 8'h01;
			end
			if (wr && reg_data == LCPC_TRIGGER_VALUE
				&& (ptr_ff == LCPC_ADDR_UPDATE || ptr_ff == LCPC_ADDR_RESET)) begin
				since_ff <= 7'h00;
			end else if (since_ff != 7'h7F) begin
				since_ff <= since_ff + 7'h01;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_reset_dark;
		$past(!nrst) |-> (channel_outputs == '0 && !device_active);
	endproperty
	a_reset_dark: assert property (p_reset_dark) else $error("dark after reset");
	property p_inactive_dark;
		!device_active [*2] |-> channel_outputs == '0;
	endproperty
	a_inactive_dark: assert property (p_inactive_dark) else $error("lit while off");
	property p_pin_off;
		!hard_power_down_n [*4] |-> !device_active;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin shutdown ignored");
	property p_pin_keep;
		!hard_power_down_n [*4] |=> $stable(current_scale);
	endproperty
	a_pin_keep: assert property (p_pin_keep) else $error("scale moved in shutdown");
	property p_reset_reg;
		wr && ptr_ff == LCPC_ADDR_RESET && reg_data == LCPC_TRIGGER_VALUE
			|-> ##2 (current_scale == '0 && channel_outputs == '0);
	endproperty
	a_reset_reg: assert property (p_reset_reg) else $error("reset write ignored");
	property p_global_off;
		wr && ptr_ff == LCPC_ADDR_GLOBAL && reg_data[0] |-> ##2 channel_outputs == '0;
	endproperty
	a_global_off: assert property (p_global_off) else $error("global off ignored");
	property p_soft_off;
		wr && ptr_ff == LCPC_ADDR_SHUTDOWN && !reg_data[0]
			|-> ##2 (!device_active && channel_outputs == '0);
	endproperty
	a_soft_off: assert property (p_soft_off) else $error("soft off ignored");
	property p_scale_cause;
		$changed(current_scale) |-> since_ff < 7'd76;
	endproperty
	a_scale_cause: assert property (p_scale_cause) else $error("scale moved unasked");
endmodule

bind lcpc_top lcpc_top_assertions #(.CLK_HZ(CLK_HZ)) i_lcpc_top_assertions (.clk(clk),
	.nrst(nrst), .reg_addr_valid(reg_addr_valid), .reg_addr(reg_addr),
	.reg_data_valid(reg_data_valid), .reg_data(reg_data), .hard_power_down_n(hard_power_down_n),
	.channel_outputs(channel_outputs), .current_scale(current_scale),
	.device_active(device_active));

// ===== verification/lcpc_host_model.sv
// Host model driving the register link and the shutdown pin
`timescale 1ns/1ns
module lcpc_host_model (
	// Clock
	input wire logic clk,
	// Register link
	output logic reg_addr_valid,
	output logic [7:0] reg_addr,
	output logic reg_data_valid,
	output logic [7:0] reg_data,
	// Shutdown pin
	output logic hard_power_down_n
);
	initial begin
		reg_addr_valid = 1'b0;
		reg_addr = 8'h00;
		reg_data_valid = 1'b0;
		reg_data = 8'h00;
		hard_power_down_n = 1'b1;
	end
	// Pointer load; idle address differs so a stale value is never mistaken
	task automatic set_ptr(input logic [7:0] a);
		@(posedge clk);
		reg_addr_valid <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_addr_valid <= 1'b0;
		reg_addr <= ~a;
	endtask
	// Valid stays up between bytes of a burst, lowered once by idle
	task automatic put(input logic [7:0] d);
		reg_data_valid <= 1'b1;
		reg_data <= d;
		@(posedge clk);
	endtask
	task automatic idle;
		reg_data_valid <= 1'b0;
		reg_data <= ~reg_data;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		set_ptr(a);
		put(d);
		idle();
	endtask
	task automatic pin(input logic v);
		@(posedge clk);
		hard_power_down_n <= v;
	endtask
endmodule

// ===== verification/lcpc_top_tb.sv
// Self-checking bench for the LED PWM controller
`timescale 1ns/1ns
module lcpc_top_tb;
	import lcpc_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic reg_addr_valid, reg_data_valid, hard_power_down_n, device_active;
	logic [7:0] reg_addr, reg_data;
	logic [LCPC_NUM_CH-1:0] channel_outputs;
	logic [2*LCPC_NUM_CH-1:0] current_scale;
	int fails = 0;
	int tests_run = 0;
	// Channel 0 scale 11, channel 35 scale 10
	localparam logic [71:0] SC = 72'h3 | (72'h2 << 70);
	always #4 clk = ~clk;
	// Small clock figure gives prescalers 4 and 1: slow period 1024 cycles, fast 256
	lcpc_top #(.CLK_HZ(3072000)) i_lcpc_top (.clk(clk), .nrst(nrst),
		.reg_addr_valid(reg_addr_valid), .reg_addr(reg_addr), .reg_data_valid(reg_data_valid),
		.reg_data(reg_data), .hard_power_down_n(hard_power_down_n),
		.channel_outputs(channel_outputs), .current_scale(current_scale),
		.device_active(device_active));
	lcpc_host_model i_lcpc_host_model (.clk(clk), .reg_addr_valid(reg_addr_valid),
		.reg_addr(reg_addr), .reg_data_valid(reg_data_valid), .reg_data(reg_data),
		.hard_power_down_n(hard_power_down_n));
	task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// On-time over n cycles for channel 0, channel 35 and both together
	task automatic meas(input int n, input int e0, input int e35, input int eb);
		int c0, c35, cb;
		c0 = 0;
		c35 = 0;
		cb = 0;
		repeat (n) begin
			@(negedge clk);
			if (channel_outputs[0] === 1'b1) c0++;
			if (channel_outputs[35] === 1'b1) c35++;
			if (channel_outputs[0] === 1'b1 && channel_outputs[35] === 1'b1) cb++;
		end
		chk("ch0 on", 72'(e0), 72'(c0));
		chk("ch35 on", 72'(e35), 72'(c35));
		chk("shared on", 72'(eb), 72'(cb));
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(negedge clk);
		chk("outputs", 72'h0, 72'(channel_outputs));
		chk("active", 72'h0, 72'(device_active));
		tdone("reset");
		i_lcpc_host_model.reg_wr(LCPC_ADDR_SHUTDOWN, 8'h01);
		repeat (2) @(negedge clk);
		chk("active", 72'h1, 72'(device_active));
		i_lcpc_host_model.reg_wr(LCPC_ADDR_DUTY_FIRST, 8'h80);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_DUTY_LAST, 8'h04);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_CTRL_FIRST, 8'h07);
		i_lcpc_host_model.set_ptr(8'h48);
		i_lcpc_host_model.put(8'h00);
		i_lcpc_host_model.put(8'h05);
		i_lcpc_host_model.idle();
		@(negedge clk);
		chk("staged scale", 72'h0, current_scale);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_UPDATE, LCPC_TRIGGER_VALUE);
		repeat (80) @(negedge clk);
		chk("scale", SC, current_scale);
		tdone("staging");
		meas(1024, 512, 16, 16);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_RATE, 8'h01);
		repeat (4) @(negedge clk);
		meas(256, 128, 4, 4);
		tdone("pwm");
		i_lcpc_host_model.reg_wr(LCPC_ADDR_GLOBAL, 8'h01);
		repeat (3) @(negedge clk);
		meas(256, 0, 0, 0);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_GLOBAL, 8'h00);
		tdone("global");
		i_lcpc_host_model.pin(1'b0);
		repeat (4) @(negedge clk);
		chk("active", 72'h0, 72'(device_active));
		i_lcpc_host_model.reg_wr(LCPC_ADDR_RESET, LCPC_TRIGGER_VALUE);
		i_lcpc_host_model.pin(1'b1);
		repeat (4) @(negedge clk);
		chk("active", 72'h1, 72'(device_active));
		chk("kept scale", SC, current_scale);
		tdone("pin");
		i_lcpc_host_model.reg_wr(LCPC_ADDR_SHUTDOWN, 8'h00);
		repeat (3) @(negedge clk);
		meas(256, 0, 0, 0);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_SHUTDOWN, 8'h01);
		repeat (3) @(negedge clk);
		meas(256, 128, 4, 4);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_DUTY_FIRST, 8'hFF);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_UPDATE, LCPC_TRIGGER_VALUE);
		repeat (80) @(negedge clk);
		meas(256, 255, 4, 4);
		tdone("soft");
		i_lcpc_host_model.reg_wr(LCPC_ADDR_RESET, 8'h55);
		repeat (3) @(negedge clk);
		chk("kept scale", SC, current_scale);
		i_lcpc_host_model.reg_wr(LCPC_ADDR_RESET, LCPC_TRIGGER_VALUE);
		repeat (3) @(negedge clk);
		chk("scale", 72'h0, current_scale);
		chk("active", 72'h0, 72'(device_active));
		tdone("soft reset");
		summarize();
	end
endmodule
